// File: rtl/nvm_row_sequencer.sv
// Operation
// - Erase only whole rows, no finer erase granularity.
// - Any address inside a row erases that entire row.
// - Key 55h then AAh must be written before a start arms.
// - Unlocked start with row-erase selected begins the erase.
// - Start is followed by two setup cycles acting as no-ops.
// - Erase stalls the core for about 2 ms until done.
// - Stall keeps clocks and peripherals running, no sleep.
// - After erase, execution resumes at third instruction after start.
// - One program writes at most the number of latches.
// - Upper 10 address bits pick row, lower 5 pick latch.
// - Programming never crosses a row boundary.
// - All latches go blank 3FFF after every write or erase.
// - Load-only set: start copies data into addressed latch only.
// - Load-only clear: load final word then program whole row.
// - Broken key-and-start sequence starts neither load nor program.
// - Writes and erases only with enable bit set; clear at reset.
// - Reset cutting off a write sets the error flag.
// - Latch load stalls the core three cycles (two setup, one load), no long stall.
// - Key register is write-only and reads zero.
module nvm_row_sequencer
  import nvm_seq_pkg::*;
#(
  parameter int ERASE_CYCLES_P = ERASE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic core_stall_out,
  output logic flash_erase_out,
  output logic flash_prog_out,
  output logic [ROW_W-1:0] flash_row_out,
  output logic [WORD_W*LATCH_COUNT-1:0] flash_wdata_out,
  input wire logic flash_done_in
);
  logic [7:0] addr_low_ff;
  logic [7:0] addr_high_ff;
  logic [7:0] data_low_ff;
  logic [7:0] data_high_ff;
  logic start_ff;
  logic enable_ff;
  logic err_ff;
  logic load_only_ff;
  logic row_erase_ff;
  logic cfg_sel_ff;
  logic op_live_ff;
  logic [WORD_W-1:0] latch_ff [LATCH_COUNT];
  seq_state_t state_ff;
  logic [1:0] slot_ff;
  logic [31:0] wait_ff;
  logic [ROW_W-1:0] row_ff;
  logic erase_ff;
  logic prog_ff;
  logic [31:0] rdata_ff;
  logic armed;
  logic access;
  logic wr_stb;
  logic ctl_wr;
  logic start_req;
  logic op_end;
  logic [ROW_W-1:0] cur_row;
  logic [LATCH_IDX_W-1:0] cur_idx;
  logic [WORD_W-1:0] cur_word;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero-wait, every access answers in its access cycle
  assign access = psel_in && penable_in;
  assign wr_stb = access && pwrite_in;
  assign ctl_wr = wr_stb && hit(paddr_in, OFF_CONTROL);
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign prdata_out = rdata_ff;
  assign cur_row = {addr_high_ff[6:0], addr_low_ff[7:5]};
  assign cur_idx = addr_low_ff[4:0];
  assign cur_word = {data_high_ff[5:0], data_low_ff};

  // Read data is registered from setup, so it is stable in the access cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      rdata_ff <= 32'h0000_0000;
      if (hit(paddr_in, OFF_ADDR_LOW)) rdata_ff[7:0] <= addr_low_ff;
      if (hit(paddr_in, OFF_ADDR_HIGH)) rdata_ff[7:0] <= {1'b0, addr_high_ff[6:0]};
      if (hit(paddr_in, OFF_DATA_LOW)) rdata_ff[7:0] <= data_low_ff;
      if (hit(paddr_in, OFF_DATA_HIGH)) rdata_ff[7:0] <= {2'b00, data_high_ff[5:0]};
      if (hit(paddr_in, OFF_CONTROL)) begin
        rdata_ff[CTL_START_BIT] <= start_ff;
        rdata_ff[CTL_ENABLE_BIT] <= enable_ff;
        rdata_ff[CTL_ERRFLAG_BIT] <= err_ff;
        rdata_ff[CTL_LOADONLY_BIT] <= load_only_ff;
        rdata_ff[CTL_ROWERASE_BIT] <= row_erase_ff;
        rdata_ff[CTL_CFGSEL_BIT] <= cfg_sel_ff;
      end
      if (hit(paddr_in, OFF_STATUS)) begin
        rdata_ff[STS_BUSY_BIT] <= (state_ff != ST_IDLE);
        rdata_ff[STS_STALL_BIT] <= core_stall_out;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address and data registers; held while busy so an operation sees fixed values
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_low_ff <= ADDR_RESET;
      addr_high_ff <= ADDR_RESET;
      data_low_ff <= ADDR_RESET;
      data_high_ff <= ADDR_RESET;
    end else if (wr_stb && state_ff == ST_IDLE) begin
      if (hit(paddr_in, OFF_ADDR_LOW)) addr_low_ff <= pwdata_in[7:0];
      if (hit(paddr_in, OFF_ADDR_HIGH)) addr_high_ff <= {1'b0, pwdata_in[6:0]};
      if (hit(paddr_in, OFF_DATA_LOW)) data_low_ff <= pwdata_in[7:0];
      if (hit(paddr_in, OFF_DATA_HIGH)) data_high_ff <= {2'b00, pwdata_in[5:0]};
    end
  end

  nvm_unlock_detect u_unlock (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_stb_in(wr_stb),
    .any_stb_in(access),
    .key_wr_in(hit(paddr_in, OFF_UNLOCK)),
    .start_wr_in(ctl_wr),
    .wdata_in(pwdata_in[7:0]),
    .armed_out(armed)
  );

  //////////////////////////////////////////////////////////////////////////////
  // start only when armed
  assign start_req = ctl_wr && pwdata_in[CTL_START_BIT] && armed && enable_ff &&
    state_ff == ST_IDLE;
  assign op_end = (state_ff == ST_DONE);

  // Control bits
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_ff <= 1'b0;
      load_only_ff <= 1'b0;
      row_erase_ff <= 1'b0;
      cfg_sel_ff <= 1'b0;
    end else if (ctl_wr && state_ff == ST_IDLE) begin
      enable_ff <= pwdata_in[CTL_ENABLE_BIT];
      load_only_ff <= pwdata_in[CTL_LOADONLY_BIT];
      row_erase_ff <= pwdata_in[CTL_ROWERASE_BIT];
      cfg_sel_ff <= pwdata_in[CTL_CFGSEL_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_ff <= 1'b0;
    end else if (start_req) begin
      start_ff <= 1'b1;
    end else if (op_end) begin
      start_ff <= 1'b0;
    end
  end

  // No reset: frozen while reset is low so a cut-off write is still seen after release
  always_ff @(posedge clk_in) begin
    if (resetn_in) begin
      op_live_ff <= (state_ff != ST_IDLE) || start_req;
    end
  end

  logic released_ff;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_ff <= 1'b0;
      released_ff <= 1'b0;
    end else begin
      released_ff <= 1'b1;
      if (!released_ff && op_live_ff) begin
        err_ff <= 1'b1;
      end else if (ctl_wr && !pwdata_in[CTL_ERRFLAG_BIT]) begin
        err_ff <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= ST_IDLE;
      slot_ff <= 2'b00;
      wait_ff <= 32'h0000_0000;
      row_ff <= '0;
      erase_ff <= 1'b0;
      prog_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_req) begin
            state_ff <= ST_SETUP;
            slot_ff <= 2'b00;
            row_ff <= cur_row;
          end
        end
        ST_SETUP: begin
          slot_ff <= slot_ff + 2'b01;
          if (slot_ff == 2'(SETUP_SLOTS - 1)) begin
            if (row_erase_ff) begin
              state_ff <= ST_ERASE;
              erase_ff <= 1'b1;
              wait_ff <= 32'(ERASE_CYCLES_P);
            end else if (load_only_ff) begin
              state_ff <= ST_LOAD;
            end else begin
              state_ff <= ST_PROG;
              prog_ff <= 1'b1;
            end
          end
        end
        ST_LOAD: state_ff <= ST_DONE;
        ST_ERASE: begin
          if (wait_ff != 32'h0000_0000) begin
            wait_ff <= wait_ff - 32'h0000_0001;
          end else if (flash_done_in) begin
            erase_ff <= 1'b0;
            state_ff <= ST_DONE;
          end
        end
        ST_PROG: begin
          if (flash_done_in) begin
            prog_ff <= 1'b0;
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write latches, one generate slice per word
  genvar gi;
  generate
    for (gi = 0; gi < LATCH_COUNT; gi++) begin : g_latch
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          latch_ff[gi] <= BLANK_WORD;
        end else if (op_end && (row_erase_ff || !load_only_ff)) begin
          latch_ff[gi] <= BLANK_WORD;
        end else if (state_ff == ST_SETUP && slot_ff == 2'b00 && !row_erase_ff &&
          cur_idx == LATCH_IDX_W'(gi)) begin
          latch_ff[gi] <= cur_word;
        end
      end
      assign flash_wdata_out[gi*WORD_W +: WORD_W] = latch_ff[gi];
    end
  endgenerate

  assign core_stall_out = (state_ff != ST_IDLE) && (state_ff != ST_DONE);
  assign flash_erase_out = erase_ff;
  assign flash_prog_out = prog_ff;
  assign flash_row_out = row_ff;

  //////////////////////////////////////////////////////////////////////////////
  property p_no_start_unarmed;
    (state_ff == ST_IDLE && !armed) |=> state_ff == ST_IDLE;
  endproperty
  a_no_start_unarmed: assert property (p_no_start_unarmed)
    else $error("operation started without unlock");
  property p_setup_two;
    start_req |=> (state_ff == ST_SETUP) [*2];
  endproperty
  a_setup_two: assert property (p_setup_two)
    else $error("setup not two cycles");
  property p_load_short;
    (start_req && pwdata_in[CTL_LOADONLY_BIT] && !pwdata_in[CTL_ROWERASE_BIT])
      |=> ##3 state_ff == ST_DONE;
  endproperty
  a_load_short: assert property (p_load_short)
    else $error("latch load took too long");
  property p_erase_stall;
    (state_ff == ST_ERASE) |-> core_stall_out && flash_erase_out;
  endproperty
  a_erase_stall: assert property (p_erase_stall)
    else $error("erase without stall");
  property p_enable_gate;
    (state_ff == ST_IDLE && !enable_ff) |=> !start_ff;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("start with enable clear");
  property p_blank_after;
    (op_end && (row_erase_ff || !load_only_ff)) |=> latch_ff[0] == BLANK_WORD;
  endproperty
  a_blank_after: assert property (p_blank_after)
    else $error("latches not blanked");
  property p_start_clears;
    op_end |=> !start_ff;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start bit not cleared");
  property p_row_held;
    (state_ff == ST_PROG) |-> $stable(flash_row_out);
  endproperty
  a_row_held: assert property (p_row_held)
    else $error("row changed during program");
  c_erase: cover property (@(posedge clk_in) state_ff == ST_ERASE ##1 state_ff == ST_DONE);
  c_prog: cover property (@(posedge clk_in) state_ff == ST_PROG ##1 state_ff == ST_DONE);
  c_load: cover property (@(posedge clk_in) state_ff == ST_LOAD);
endmodule

// File: rtl/nvm_seq_pkg.sv
package nvm_seq_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFF_DATA_LOW = 8'h08;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Control register field positions
  localparam int CTL_START_BIT = 0;
  localparam int CTL_ENABLE_BIT = 1;
  localparam int CTL_ERRFLAG_BIT = 2;
  localparam int CTL_LOADONLY_BIT = 3;
  localparam int CTL_ROWERASE_BIT = 4;
  localparam int CTL_CFGSEL_BIT = 6;
  // Status register field positions
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_STALL_BIT = 1;
  // Key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Array geometry
  localparam int LATCH_COUNT = 32;
  localparam int LATCH_IDX_W = 5;
  localparam int ROW_W = 10;
  localparam int WORD_W = 14;
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES = (CLK_HZ / 1000000) * ERASE_TIME_US;
  localparam int SETUP_SLOTS = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOAD = 3'b010,
    ST_PROG = 3'b011,
    ST_ERASE = 3'b100,
    ST_DONE = 3'b101
  } seq_state_t;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT1 = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;
endpackage

// File: rtl/nvm_unlock_detect.sv
module nvm_unlock_detect
  import nvm_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_stb_in,
  input wire logic any_stb_in,
  input wire logic key_wr_in,
  input wire logic start_wr_in,
  input wire logic [7:0] wdata_in,
  output logic armed_out
);
  key_state_t key_ff;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  //////////////////////////////////////////////////////////////////////////////
  // exact key order
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      key_ff <= KEY_IDLE;
    end else if (key_wr_in && wr_stb_in) begin
      if (wdata_in == KEY_FIRST) begin
        key_ff <= KEY_GOT1;
      end else if (wdata_in == KEY_SECOND && key_ff == KEY_GOT1) begin
        key_ff <= KEY_ARMED;
      end else begin
        key_ff <= KEY_IDLE;
      end
    end else if (any_stb_in && !start_wr_in) begin
      key_ff <= KEY_IDLE;
    end else if (start_wr_in) begin
      // Key is spent by any control write, start or not
      key_ff <= KEY_IDLE;
    end
  end

  assign armed_out = (key_ff == KEY_ARMED);

  property p_arm_needs_second_key;
    $rose(armed_out) |-> $past(key_wr_in && wr_stb_in && wdata_in == KEY_SECOND);
  endproperty
  a_arm_needs_second_key: assert property (p_arm_needs_second_key)
    else $error("armed without AAh key write");
  property p_break_disarms;
    (armed_out && any_stb_in && !start_wr_in) |=> !armed_out;
  endproperty
  a_break_disarms: assert property (p_break_disarms)
    else $error("foreign access did not disarm");
endmodule

// File: sim/flash_array_model.sv
module flash_array_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic erase_in,
  input wire logic prog_in,
  input wire logic [7:0] delay_in,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////
  // Busy time of the array; delay 0 answers at once, larger values slowly
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff <= 8'h00;
    end else if (!(erase_in || prog_in)) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != delay_in) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Done is low outside an operation, so a stale level never leaks
  assign done_out = (erase_in || prog_in) && (cnt_ff == delay_in);
endmodule

// File: sim/flash_row_erase_write_sequencer_bench.sv
module flash_row_erase_write_sequencer_bench;
  import nvm_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ERASE_CYC = 20;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, core_stall_out, flash_erase_out, flash_prog_out, done;
  logic [ROW_W-1:0] flash_row_out, cap_row;
  logic [WORD_W*LATCH_COUNT-1:0] flash_wdata_out, cap_data, img;
  logic [7:0] delay = 8'h00;
  logic act_prev = 1'b0;
  logic cap_erase;
  logic [31:0] q;
  int stall_total = 0, ops = 0, s0, o0, miscompares = 0, n_checks = 0;

  always #12.5 clk_in = ~clk_in;

  nvm_row_sequencer #(.ERASE_CYCLES_P(ERASE_CYC)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .core_stall_out(core_stall_out),
    .flash_erase_out(flash_erase_out), .flash_prog_out(flash_prog_out),
    .flash_row_out(flash_row_out), .flash_wdata_out(flash_wdata_out), .flash_done_in(done));
  flash_array_model far (.clk_in(clk_in), .resetn_in(resetn_in), .erase_in(flash_erase_out),
    .prog_in(flash_prog_out), .delay_in(delay), .done_out(done));

  ////////////////////////////////////////////////////////////////////////
  // Counts stall cycles and snapshots each array operation as it starts
  always @(posedge clk_in) begin
    act_prev <= flash_prog_out || flash_erase_out;
    if (core_stall_out === 1'b1) stall_total <= stall_total + 1;
    if ((flash_prog_out || flash_erase_out) && !act_prev) begin
      ops <= ops + 1;
      cap_row <= flash_row_out;
      cap_data <= flash_wdata_out;
      cap_erase <= flash_erase_out;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [447:0] e, input logic [447:0] g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %0h seen %0h", nm, e, g);
      miscompares++;
    end
  endtask

  // One APB transfer; waits an edge first so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    q = prdata_out;
    if (i == 50) begin
      miscompares++;
      test_done();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (q[STS_BUSY_BIT] === 1'b0) break;
    end
    if (i == 200) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic unlock;
    apb(1'b1, OFF_UNLOCK, 32'h55);
    apb(1'b1, OFF_UNLOCK, 32'hAA);
  endtask

  // Address, data, key, start: the firmware order for one latch word
  task automatic put(input logic [4:0] idx, input logic [13:0] w, input logic [7:0] ctl);
    apb(1'b1, OFF_ADDR_LOW, {24'h0, 3'b101, idx});
    apb(1'b1, OFF_DATA_LOW, {24'h0, w[7:0]});
    apb(1'b1, OFF_DATA_HIGH, {26'h0, w[13:8]});
    unlock();
    apb(1'b1, OFF_CONTROL, {24'h0, ctl});
    wait_idle();
    img[idx*WORD_W +: WORD_W] = w;
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    apb(1'b0, OFF_CONTROL, 32'h0);
    chk("control after reset", 32'h0, q);
    apb(1'b1, OFF_UNLOCK, 32'h55);
    apb(1'b0, OFF_UNLOCK, 32'h0);
    chk("key readback", 32'h0, q);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped read", 32'h0, q);
    chk("unmapped error", 1'b0, pslverr_out);
    apb(1'b1, OFF_ADDR_HIGH, 32'h2A);
    // Erase from a mid-row address with a slow array
    delay = 8'h09;
    s0 = stall_total;
    o0 = ops;
    apb(1'b1, OFF_ADDR_LOW, 32'hBB);
    apb(1'b1, OFF_CONTROL, 32'h12);
    unlock();
    apb(1'b1, OFF_CONTROL, 32'h13);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status in erase", 32'h3, q & 32'h3);
    wait_idle();
    chk("erase started", o0 + 1, ops);
    chk("erase kind", 1'b1, cap_erase);
    chk("erase row", 10'h155, cap_row);
    chk("erase stall", 1'b1, (stall_total - s0) >= ERASE_CYC + SETUP_SLOTS);
    apb(1'b0, OFF_CONTROL, 32'h0);
    chk("start cleared", 1'b0, q[CTL_START_BIT]);
    // Latch fill at both row ends, then program with the final word
    delay = 8'h00;
    img = {LATCH_COUNT{BLANK_WORD}};
    s0 = stall_total;
    o0 = ops;
    put(5'd0, 14'h1234, 8'h0B);
    chk("load stall", 1'b1, (stall_total - s0) >= 2 && (stall_total - s0) <= 4);
    put(5'd31, 14'h2ABC, 8'h0B);
    chk("no program on load", o0, ops);
    put(5'd5, 14'h0F0F, 8'h03);
    chk("program started", o0 + 1, ops);
    chk("program row", 10'h155, cap_row);
    chk("program image", img, cap_data);
    // Latches blank again after the write
    img = {LATCH_COUNT{BLANK_WORD}};
    put(5'd7, 14'h0777, 8'h03);
    chk("blank after write", img, cap_data);
    // Broken key orders and a missing enable must start nothing
    o0 = ops;
    apb(1'b1, OFF_UNLOCK, 32'hAA);
    apb(1'b1, OFF_UNLOCK, 32'h55);
    apb(1'b1, OFF_CONTROL, 32'h0B);
    apb(1'b1, OFF_CONTROL, 32'h0);
    unlock();
    apb(1'b0, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h03);
    apb(1'b1, OFF_CONTROL, 32'h0);
    unlock();
    apb(1'b1, OFF_CONTROL, 32'h01);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("idle after refusals", 1'b0, q[STS_BUSY_BIT]);
    chk("no operation", o0, ops);
    // Reset in mid-erase leaves the error flag
    delay = 8'h09;
    apb(1'b1, OFF_CONTROL, 32'h12);
    unlock();
    apb(1'b1, OFF_CONTROL, 32'h13);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    apb(1'b0, OFF_CONTROL, 32'h0);
    chk("error flag set", 1'b1, q[CTL_ERRFLAG_BIT]);
    apb(1'b1, OFF_CONTROL, 32'h0);
    apb(1'b0, OFF_CONTROL, 32'h0);
    chk("error flag cleared", 1'b0, q[CTL_ERRFLAG_BIT]);
    test_done();
  end
endmodule
